/* hdl/nhr_host_ctrl.v */
// Host-side controller that drives a paged NAND through its strobes and shared bus.
// Assumes a pulled-up ready_busy_n line sampled synchronously; read data kept in a page buffer.
`timescale 1ns/1ps
`default_nettype none
`include "nhr_defs.vh"

module nhr_host_ctrl (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// User request
	input wire reqValid,
	input wire reqDual,
	input wire reqColChg,
	input wire [12:0] reqColumn,
	input wire [16:0] reqRow,
	input wire [16:0] reqRow2,
	input wire [12:0] reqLength,
	output reg reqReady,
	output reg reqError,
	output reg reqDone,
	// Read data out
	output reg [7:0] rdByte,
	output reg rdByteValid,
	// NAND pins
	output reg cmdLatch,
	output reg addrLatch,
	output reg chipSel_n,
	output reg writeStrobe_n,
	output reg read_strobe_n,
	output reg writeProt_n,
	input wire [7:0] shared_bus_in,
	output reg [7:0] shared_bus_out,
	output reg shared_bus_oe,
	input wire ready_busy_n
);
	localparam ST_IDLE = 4'h0;
	localparam ST_WR_LO = 4'h1;
	localparam ST_WR_HI = 4'h2;
	localparam ST_NEXT = 4'h3;
	localparam ST_BUSY_W = 4'h4;
	localparam ST_WAIT_RDY = 4'h5;
	localparam ST_RD_LO = 4'h6;
	localparam ST_RD_HI = 4'h7;
	localparam ST_FIN = 4'h8;

	// Step kinds
	localparam K_CMD = 2'h0;
	localparam K_ADR = 2'h1;
	localparam K_END = 2'h2;

	reg [3:0] state_r;
	reg [3:0] step_r;
	reg [7:0] cnt_r;
	reg [12:0] left_r;
	reg [12:0] col_r;
	reg [16:0] row_r;
	reg [16:0] row2_r;
	reg dual_r;
	reg chg_r;
	reg [9:0] stepInfo;
	reg [12:0] bufWrAddr_r;
	wire [7:0] bufRd;

	function [7:0] addrByte;
		input [2:0] idx;
		input [12:0] col;
		input [16:0] row;
		begin
			case (idx)
				3'h0: addrByte = col[7:0];
				3'h1: addrByte = {3'h0, col[12:8]};
				3'h2: addrByte = row[7:0];
				3'h3: addrByte = row[15:8];
				3'h4: addrByte = {7'h00, row[16]};
				default: addrByte = 8'h00;
			endcase
		end
	endfunction

	// Step table: {kind, byte or address index}; index bit 7 picks the second row
	always @* begin
		stepInfo = {K_END, 8'h00};
		if (chg_r) begin
			case (step_r)
				4'h0: stepInfo = {K_CMD, `NHR_CMD_COL_CHG};
				4'h1: stepInfo = {K_ADR, 8'h00};
				4'h2: stepInfo = {K_ADR, 8'h01};
				4'h3: stepInfo = {K_CMD, `NHR_CMD_COL_CHG_CONF};
				default: stepInfo = {K_END, 8'h00};
			endcase
		end else if (dual_r) begin
			case (step_r)
				4'h0: stepInfo = {K_CMD, `NHR_CMD_DUAL_SETUP};
				4'h1, 4'h2, 4'h3, 4'h4, 4'h5: stepInfo = {K_ADR, 4'h0, step_r - 4'h1};
				4'h6: stepInfo = {K_CMD, `NHR_CMD_DUAL_SETUP};
				4'h7, 4'h8, 4'h9, 4'hA, 4'hB: stepInfo = {K_ADR, 4'h8, step_r - 4'h7};
				4'hC: stepInfo = {K_CMD, `NHR_CMD_READ_CONFIRM};
				default: stepInfo = {K_END, 8'h00};
			endcase
		end else begin
			// Single page read; setup resent anyway
			case (step_r)
				4'h0: stepInfo = {K_CMD, `NHR_CMD_READ_SETUP};
				4'h1, 4'h2, 4'h3, 4'h4, 4'h5: stepInfo = {K_ADR, 4'h0, step_r - 4'h1};
				4'h6: stepInfo = {K_CMD, `NHR_CMD_READ_CONFIRM};
				default: stepInfo = {K_END, 8'h00};
			endcase
		end
	end

	// Group from block parity; legality of a dual request
	wire dualBad = (reqRow[`NHR_BLOCK_LSB] == reqRow2[`NHR_BLOCK_LSB]) ||
		(reqRow[5:0] != reqRow2[5:0]);
	// Column plus length stays inside page
	wire lenBad = (reqLength == 13'h0000) ||
		({1'b0, reqColumn} + {1'b0, reqLength} > {1'b0, `NHR_PAGE_BYTES});
	wire [7:0] stepByte = (stepInfo[9:8] == K_CMD) ? stepInfo[7:0] :
		addrByte(stepInfo[2:0], col_r, stepInfo[7] ? row2_r : row_r);

	nhr_read_buf uBuf (
		.core_clk(core_clk),
		.wrEn(rdByteValid),
		.wrAddr(bufWrAddr_r),
		.wrData(rdByte),
		.rdAddr(col_r),
		.rdData(bufRd)
	);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			step_r <= 4'h0;
			cnt_r <= 8'h00;
			left_r <= 13'h0000;
			col_r <= 13'h0000;
			row_r <= 17'h00000;
			row2_r <= 17'h00000;
			dual_r <= 1'b0;
			chg_r <= 1'b0;
			bufWrAddr_r <= 13'h0000;
			reqReady <= 1'b0;
			reqError <= 1'b0;
			reqDone <= 1'b0;
			rdByte <= 8'h00;
			rdByteValid <= 1'b0;
			cmdLatch <= 1'b0;
			addrLatch <= 1'b0;
			chipSel_n <= 1'b1;
			writeStrobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			writeProt_n <= 1'b0;
			shared_bus_out <= 8'h00;
			shared_bus_oe <= 1'b0;
		end else begin
			reqError <= 1'b0;
			reqDone <= 1'b0;
			rdByteValid <= 1'b0;
			// Reads only: keep program and erase locked out
			writeProt_n <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					reqReady <= 1'b1;
					if (ready_busy_n)
						chipSel_n <= 1'b1;
					if (reqValid && reqReady) begin
						reqReady <= 1'b0;
						if (lenBad || (reqDual && dualBad)) begin
							reqError <= 1'b1;
						end else begin
							col_r <= reqColumn;
							row_r <= reqRow;
							row2_r <= reqRow2;
							dual_r <= reqDual;
							chg_r <= reqColChg;
							left_r <= reqLength;
							step_r <= 4'h0;
							bufWrAddr_r <= reqColumn;
							chipSel_n <= 1'b0;
							state_r <= ST_WAIT_RDY;
						end
					end
				end
				ST_WR_LO: begin
					// Set latch selects and drive byte
					cmdLatch <= (stepInfo[9:8] == K_CMD);
					addrLatch <= (stepInfo[9:8] == K_ADR);
					shared_bus_out <= stepByte;
					shared_bus_oe <= 1'b1;
					writeStrobe_n <= 1'b0;
					cnt_r <= 8'h00;
					state_r <= ST_WR_HI;
				end
				ST_WR_HI: begin
					cnt_r <= cnt_r + 8'h01;
					if ({24'h000000, cnt_r} == `NHR_TWP_CYC)
						writeStrobe_n <= 1'b1;
					if ({24'h000000, cnt_r} == (`NHR_TWP_CYC + `NHR_TWH_CYC)) begin
						step_r <= step_r + 4'h1;
						state_r <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					cmdLatch <= 1'b0;
					addrLatch <= 1'b0;
					cnt_r <= 8'h00;
					if (stepInfo[9:8] != K_END)
						state_r <= ST_WR_LO;
					else if (chg_r) begin
						shared_bus_oe <= 1'b0;
						state_r <= ST_WAIT_RDY;
					end else begin
						shared_bus_oe <= 1'b0;
						state_r <= ST_BUSY_W;
					end
				end
				ST_BUSY_W: begin
					// Wait for busy; strobes stay high
					cnt_r <= cnt_r + 8'h01;
					if (!ready_busy_n || cnt_r == 8'h40) begin
						cnt_r <= 8'h00;
						state_r <= ST_WAIT_RDY;
					end
				end
				ST_WAIT_RDY: begin
					if (!ready_busy_n)
						cnt_r <= 8'h00;
					else if ({24'h000000, cnt_r} == (`NHR_TWHR_CYC + `NHR_TRR_CYC)) begin
						cnt_r <= 8'h00;
						if (stepInfo[9:8] != K_END)
							state_r <= ST_WR_LO;
						else
							state_r <= ST_RD_LO;
					end else
						cnt_r <= cnt_r + 8'h01;
				end
				ST_RD_LO: begin
					// Fall of read strobe delivers a byte
					read_strobe_n <= 1'b0;
					cnt_r <= 8'h00;
					state_r <= ST_RD_HI;
				end
				ST_RD_HI: begin
					cnt_r <= cnt_r + 8'h01;
					if ({24'h000000, cnt_r} == `NHR_TRP_CYC) begin
						rdByte <= shared_bus_in;
						rdByteValid <= 1'b1;
						read_strobe_n <= 1'b1;
						left_r <= left_r - 13'h0001;
					end
					if ({24'h000000, cnt_r} == (`NHR_TRP_CYC + `NHR_TREH_CYC)) begin
						bufWrAddr_r <= bufWrAddr_r + 13'h0001;
						state_r <= (left_r == 13'h0000) ? ST_FIN : ST_RD_LO;
					end
				end
				ST_FIN: begin
					reqDone <= 1'b1;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule // nhr_host_ctrl

`default_nettype wire

/* common/nhr_defs.vh */
// Constants for the NAND host read controller: commands, address layout, timing.
// Assumes a 250 MHz core clock; included by bare name.
`ifndef NHR_DEFS_VH
`define NHR_DEFS_VH

`define NHR_CLK_PERIOD_PS 4000
`define NHR_CMD_READ_SETUP 8'h00
`define NHR_CMD_READ_CONFIRM 8'h30
`define NHR_CMD_COL_CHG 8'h05
`define NHR_CMD_COL_CHG_CONF 8'hE0
`define NHR_CMD_DUAL_SETUP 8'h60
`define NHR_CMD_STATUS 8'h70
`define NHR_CMD_STATUS_DUAL 8'h71
`define NHR_CMD_ECC_STATUS 8'h7A
`define NHR_CMD_RESET 8'hFF
`define NHR_COL_W 13
`define NHR_ROW_W 17
`define NHR_PAGE_LSB 0
`define NHR_PAGE_W 6
`define NHR_BLOCK_LSB 6
`define NHR_BLOCK_W 11
`define NHR_PAGE_BYTES 13'h1080
`define NHR_ADDR_CYCLES 3'h5
`define NHR_COLCHG_CYCLES 3'h2
// Strobe timing in ns, cycles derived (least times round up)
`define NHR_TWP_NS 12
`define NHR_TWH_NS 10
`define NHR_TRP_NS 12
`define NHR_TREH_NS 10
`define NHR_TWHR_NS 60
`define NHR_TRR_NS 20
`define NHR_TREA_NS 20
`define NHR_CYC(ns) ((((ns) * 1000) + `NHR_CLK_PERIOD_PS - 1) / `NHR_CLK_PERIOD_PS)
`define NHR_TWP_CYC `NHR_CYC(`NHR_TWP_NS)
`define NHR_TWH_CYC `NHR_CYC(`NHR_TWH_NS)
`define NHR_TRP_CYC `NHR_CYC(`NHR_TREA_NS + 4)
`define NHR_TREH_CYC `NHR_CYC(`NHR_TREH_NS)
`define NHR_TWHR_CYC `NHR_CYC(`NHR_TWHR_NS)
`define NHR_TRR_CYC `NHR_CYC(`NHR_TRR_NS)

`endif

/* hdl/nhr_read_buf.v */
// Page buffer for read data, one byte per column.
// Assumes single clock; read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "nhr_defs.vh"

module nhr_read_buf (
	// Clock
	input wire core_clk,
	// Write side
	input wire wrEn,
	input wire [12:0] wrAddr,
	input wire [7:0] wrData,
	// Read side
	input wire [12:0] rdAddr,
	output reg [7:0] rdData
);
	reg [7:0] mem [0:4223];

	always @(posedge core_clk) begin
		if (wrEn)
			mem[wrAddr] <= wrData;
		rdData <= mem[rdAddr];
	end
endmodule // nhr_read_buf

`default_nettype wire

/* tb/nhr_host_ctrl_asserts.sv */
// Pin-level checker for the NAND host read controller.
// Assumes binding to nhr_host_ctrl; ready_busy_n pulled up outside.
`timescale 1ns/1ps
`default_nettype none
module nhr_host_ctrl_asserts (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Device pins
	input wire logic cmdLatch,
	input wire logic addrLatch,
	input wire logic chipSel_n,
	input wire logic writeStrobe_n,
	input wire logic read_strobe_n,
	input wire logic writeProt_n,
	input wire logic [7:0] shared_bus_out,
	input wire logic shared_bus_oe,
	input wire logic ready_busy_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence wrRise;
		$rose(writeStrobe_n);
	endsequence
	a_wp_held: assert property (!writeProt_n) else $error("wp high");
	a_latch_excl: assert property (!(cmdLatch && addrLatch)) else $error("both latches");
	a_strobe_excl: assert property (writeStrobe_n || read_strobe_n) else $error("both strobes");
	a_bus_drive: assert property (!writeStrobe_n |-> shared_bus_oe) else $error("bus undriven");
	a_bus_free: assert property (!read_strobe_n |-> !shared_bus_oe) else $error("bus clash");
	a_latch_hold: assert property (wrRise |-> $stable(cmdLatch) && $stable(addrLatch)) else $error("latch hold");
	a_data_hold: assert property (wrRise |-> $stable(shared_bus_out)) else $error("data hold");
	a_busy_quiet: assert property (!ready_busy_n && !chipSel_n |-> writeStrobe_n && read_strobe_n)
		else $error("strobe in busy");
	a_cmd_legal: assert property (wrRise ##0 cmdLatch |-> shared_bus_out inside {8'h00, 8'h05, 8'h30, 8'h60, 8'hE0})
		else $error("command outside read set");
	a_read_ready: assert property ($fell(read_strobe_n) |-> ready_busy_n) else $error("read in busy");
	a_idle_ready: assert property ($rose(chipSel_n) |-> $past(ready_busy_n)) else $error("deselect busy");
endmodule // nhr_host_ctrl_asserts
bind nhr_host_ctrl nhr_host_ctrl_asserts nhr_host_ctrl_asserts_i (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.cmdLatch(cmdLatch),
	.addrLatch(addrLatch),
	.chipSel_n(chipSel_n),
	.writeStrobe_n(writeStrobe_n),
	.read_strobe_n(read_strobe_n),
	.writeProt_n(writeProt_n),
	.shared_bus_out(shared_bus_out),
	.shared_bus_oe(shared_bus_oe),
	.ready_busy_n(ready_busy_n)
);
`default_nettype wire

/* tb/nhr_nand_model.sv */
// Behavioural paged NAND device seen from its pins.
// Assumes the bench pulls ready/busy up and merges the shared bus.
`timescale 1ns/1ps
`default_nettype none
module nhr_nand_model (
	// Host strobes
	input wire logic cmdLatch,
	input wire logic addrLatch,
	input wire logic chipSel_n,
	input wire logic writeStrobe_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] shared_bus_out,
	// Bench control
	input wire logic [15:0] busyNs,
	// Device outputs
	output logic [7:0] devBus,
	output logic rbLow
);
	logic [7:0] ab [0:4];
	logic [2:0] n = 3'h0;
	logic [12:0] col;
	logic [16:0] row;
	initial begin
		rbLow = 1'h0;
		devBus = 8'h5A;
	end
	always @(posedge writeStrobe_n) if (!chipSel_n) begin
		if (addrLatch && n < 3'h5) begin
			ab[n] = shared_bus_out;
			n = n + 3'h1;
		end
		if (cmdLatch && !rbLow) case (shared_bus_out)
			8'h00, 8'h05, 8'h60: n = 3'h0;
			8'hE0: col = {ab[1][4:0], ab[0]};
			8'h30: begin
				col = {ab[1][4:0], ab[0]};
				row = {ab[4][0], ab[3], ab[2]};
				rbLow = 1'h1;
				rbLow <= #(busyNs) 1'h0;
			end
		endcase
	end
	always @(negedge read_strobe_n) if (!chipSel_n && !rbLow) begin
		devBus <= #20 col[7:0] ^ {3'h0, col[12:8]} ^ {2'h0, row[5:0]} ^ row[15:8] ^ {7'h0, row[16]};
		col = col + 13'h1;
	end
	// Released bus must not look like valid data
	always @(posedge read_strobe_n) devBus <= ~devBus;
endmodule // nhr_nand_model
`default_nettype wire

/* tb/test_nhr_host_ctrl.sv */
// Self-checking bench for the NAND host read controller.
// Assumes nhr_nand_model on the pins and a pull-up on ready/busy.
`timescale 1ns/1ps
`default_nettype none
module test_nhr_host_ctrl;
	logic core_clk, rst_n, reqValid, reqDual, reqColChg;
	logic [12:0] reqColumn, reqLength, c;
	logic [16:0] reqRow, reqRow2, r;
	logic [15:0] busyNs;
	wire reqReady, reqError, reqDone, rdByteValid, cmdLatch, addrLatch, chipSel_n;
	wire writeStrobe_n, read_strobe_n, writeProt_n, shared_bus_oe, rbLow, ready_busy_n;
	wire [7:0] rdByte, shared_bus_out, devBus, shared_bus_in;
	logic [7:0] expQ[$];
	int num_errors, num_checks, i;
	assign ready_busy_n = rbLow ? 1'h0 : 1'h1;
	assign shared_bus_in = shared_bus_oe ? shared_bus_out : devBus;
	nhr_host_ctrl nhr_host_ctrl_i (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.reqValid(reqValid),
		.reqDual(reqDual),
		.reqColChg(reqColChg),
		.reqColumn(reqColumn),
		.reqRow(reqRow),
		.reqRow2(reqRow2),
		.reqLength(reqLength),
		.reqReady(reqReady),
		.reqError(reqError),
		.reqDone(reqDone),
		.rdByte(rdByte),
		.rdByteValid(rdByteValid),
		.cmdLatch(cmdLatch),
		.addrLatch(addrLatch),
		.chipSel_n(chipSel_n),
		.writeStrobe_n(writeStrobe_n),
		.read_strobe_n(read_strobe_n),
		.writeProt_n(writeProt_n),
		.shared_bus_in(shared_bus_in),
		.shared_bus_out(shared_bus_out),
		.shared_bus_oe(shared_bus_oe),
		.ready_busy_n(ready_busy_n)
	);
	nhr_nand_model nhr_nand_model_i (
		.cmdLatch(cmdLatch),
		.addrLatch(addrLatch),
		.chipSel_n(chipSel_n),
		.writeStrobe_n(writeStrobe_n),
		.read_strobe_n(read_strobe_n),
		.shared_bus_out(shared_bus_out),
		.busyNs(busyNs),
		.devBus(devBus),
		.rbLow(rbLow)
	);
	function automatic logic [7:0] dat(logic [12:0] k, logic [16:0] w);
		return k[7:0] ^ {3'h0, k[12:8]} ^ {2'h0, w[5:0]} ^ w[15:8] ^ {7'h0, w[16]};
	endfunction
	task automatic chk(string nm, logic [12:0] ex, logic [12:0] sn);
		num_checks++;
		if (ex !== sn) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic req(logic d, logic g, logic [12:0] col, logic [16:0] w, logic [16:0] w2, logic [12:0] n, logic e);
		int k;
		for (k = 0; k < n && !e; k++) expQ.push_back(dat(col + 13'(k), d ? w2 : w));
		@(posedge core_clk);
		while (reqReady !== 1'h1) @(posedge core_clk);
		reqDual <= d;
		reqColChg <= g;
		reqColumn <= col;
		reqRow <= w;
		reqRow2 <= w2;
		reqLength <= n;
		busyNs <= 16'($urandom_range(32'hBB8, 32'h3C));
		reqValid <= 1'h1;
		@(posedge core_clk);
		reqValid <= 1'h0;
		k = 0;
		while (reqDone !== 1'h1 && reqError !== 1'h1 && k < 20000) begin
			@(posedge core_clk);
			k++;
		end
		chk("error", {12'h0, e}, {12'h0, reqError});
		chk("done", {12'h0, ~e}, {12'h0, reqDone});
		chk("left", 13'h0, 13'(expQ.size()));
		$display("test done col %h len %h", col, n);
	endtask
	always @(posedge core_clk) if (rdByteValid === 1'h1) begin
		if (expQ.size() == 0) chk("extra", 13'h0, 13'h1);
		else chk("byte", {5'h0, expQ.pop_front()}, {5'h0, rdByte});
	end
	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		num_errors++;
		test_done;
	end
	initial begin
		{rst_n, reqValid, reqDual, reqColChg, reqColumn, reqLength, reqRow, reqRow2} = '0;
		busyNs = 16'h3C;
		num_errors = 0;
		num_checks = 0;
		void'($urandom(88));
		repeat (16) @(posedge core_clk);
		rst_n <= 1'h1;
		for (i = 0; i < 3; i++) begin
			c = 13'($urandom_range(32'hFFF, 32'h0));
			r = 17'($urandom);
			req(1'h0, 1'h0, c, r, r, 13'($urandom_range(32'h6, 32'h1)), 1'h0);
		end
		req(1'h0, 1'h1, c + 13'h10, r, r, 13'h3, 1'h0);
		req(1'h0, 1'h0, 13'h107F, r, r, 13'h1, 1'h0);
		req(1'h0, 1'h0, 13'h107F, r, r, 13'h2, 1'h1);
		req(1'h0, 1'h0, 13'h0, r, r, 13'h0, 1'h1);
		req(1'h1, 1'h0, c, r, r ^ 17'h40, 13'h4, 1'h0);
		req(1'h1, 1'h0, c, r, r ^ 17'h80, 13'h2, 1'h1);
		req(1'h1, 1'h0, c, r, r ^ 17'h41, 13'h2, 1'h1);
		test_done;
	end
endmodule // test_nhr_host_ctrl
`default_nettype wire
